/* File: verilog/dfs_pkg.sv */
// Shared constants, types and states for the disk sector format sequencer
// Behaviour
// - Drop read enable before any write splice
// - Reassert read enable past splice, 11 bytes left; rd_en_q here stays low throughout
// - Intersector gap: 16 bytes, 4 before, 12 after
// - Address area opens with 11 zero sync bytes
// - One chosen byte sync pattern follows sync
// - Address field: flag, cylinder x2, head, sector
// - Generate two-byte address check code
// - One pad byte after address check code
// - One-byte write splice opens data area
// - Eleven zero bytes before data sync pattern
// - Generate two-byte data check code
// - One pad byte after data check code
// - Wait ready, 5 us after head change
// - Index edge raises write enable, 12+11 zeros
// - Sync, address, check, then 13 zero bytes
// - Data sync, fill field, check, pad byte
// - Sector ends with four zero gap bytes
// - Repeat per sector; zeros until index, release
// - Write enable off 1 us before head change
// - Write clock returned 2.5 periods before enable
package dfs_pkg;

  // System clock and drive timing
  localparam int CLK_NS = 20;
  localparam int HEAD_SETTLE_NS = 5000;
  localparam int WE_OFF_NS = 1000;
  localparam int HEAD_SETTLE_CYC = (HEAD_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_OFF_CYC = (WE_OFF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] HEAD_SETTLE_CNT = 8'(HEAD_SETTLE_CYC);
  localparam logic [7:0] WE_OFF_CNT = 8'(WE_OFF_CYC);
  // Write clock lead in half servo periods, rounded up to whole periods
  localparam int WCLK_LEAD_HALF = 5;
  localparam logic [1:0] WCLK_LEAD_CNT = 2'((WCLK_LEAD_HALF + 1) / 2);

  // Sector layout, byte offsets from the sector or index edge
  localparam logic [15:0] GAP_HEAD_BYTES = 16'h000c;
  localparam logic [15:0] SYNC_BYTES = 16'h000b;
  localparam logic [15:0] ADR_BYTES = 16'h0005;
  localparam logic [15:0] CRC_BYTES = 16'h0002;
  localparam logic [15:0] PAD_BYTES = 16'h0001;
  localparam logic [15:0] SPLICE_BYTES = 16'h0001;
  localparam logic [15:0] ASB_POS = GAP_HEAD_BYTES + SYNC_BYTES;
  localparam logic [15:0] ADR_POS = ASB_POS + 16'h0001;
  localparam logic [15:0] ACRC_POS = ADR_POS + ADR_BYTES;
  localparam logic [15:0] DSB_POS = ACRC_POS + CRC_BYTES + PAD_BYTES + SPLICE_BYTES + SYNC_BYTES;
  localparam logic [15:0] DAT_POS = DSB_POS + 16'h0001;

  // Check code: 16-bit cyclic code
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // Pin vector positions in the link domain
  localparam int PIN_BYTE = 0;
  localparam int PIN_INDEX = 1;
  localparam int PIN_SECTOR = 2;

  // Format job, held stable while a job runs
  typedef struct packed {
    logic [7:0] sync_pat;
    logic [7:0] flag;
    logic [15:0] cyl;
    logic [1:0] head;
    logic [7:0] n_sect;
    logic [15:0] data_len;
    logic [7:0] fill;
    logic head_only;
  } dfs_cfg_t;

  // Drive-side write lines
  typedef struct packed {
    logic wr_en;
    logic wr_data;
    logic wr_clk_gate;
  } dfs_wr_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_WREADY = 3'h1,
    S_HWAIT = 3'h3,
    S_RUN = 3'h2,
    S_HOLD = 3'h6
  } dfs_sys_st_t;

  typedef enum logic [1:0] {
    L_IDLE = 2'h0,
    L_ARM = 2'h1,
    L_FMT = 2'h3,
    L_LAST = 2'h2
  } dfs_lnk_st_t;

endpackage

/* File: verilog/dfs_format_seq.sv */
// Controller-side track formatter driving the drive's write lines
`timescale 1ns/1ps
module dfs_format_seq (
  // System clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Job request
  input wire logic start,
  input wire dfs_pkg::dfs_cfg_t cfg,
  output logic busy_q,
  output logic done_q,
  // Drive command lines
  input wire logic ready_pin,
  output logic unit_sel_q,
  output logic [1:0] head_sel_q,
  output logic rd_en_q,
  // Drive data cable, servo clock domain
  input wire logic srv_clk,
  input wire logic byte_clk_pin,
  input wire logic index_pin,
  input wire logic sector_pin,
  output dfs_pkg::dfs_wr_t wr_q
);

  // CRC over one byte, MSB first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ b[i]) begin
        r = {r[14:0], 1'b0} ^ dfs_pkg::CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // ---------------- System domain ----------------
  dfs_pkg::dfs_sys_st_t st_q;
  dfs_pkg::dfs_cfg_t cfg_q;
  logic [7:0] tmr_q;
  logic rdy_s1_q, rdy_s2_q;
  logic go_tgl_q;
  logic done_tgl_q;
  logic dn_s1_q, dn_s2_q, dn_s3_q;
  logic done_evt;

  // Ready pin and done toggle synchronisers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
      dn_s1_q <= 1'b0;
      dn_s2_q <= 1'b0;
      dn_s3_q <= 1'b0;
    end else begin
      rdy_s1_q <= ready_pin;
      rdy_s2_q <= rdy_s1_q;
      dn_s1_q <= done_tgl_q;
      dn_s2_q <= dn_s1_q;
      dn_s3_q <= dn_s2_q;
    end
  end

  assign done_evt = dn_s2_q ^ dn_s3_q;

  // Job sequencing; busy covers the write-enable release time as well
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= dfs_pkg::S_IDLE;
      tmr_q <= 8'h00;
      go_tgl_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        dfs_pkg::S_IDLE: begin
          if (start) begin
            st_q <= dfs_pkg::S_WREADY;
            busy_q <= 1'b1;
            tmr_q <= dfs_pkg::HEAD_SETTLE_CNT;
          end
        end
        dfs_pkg::S_WREADY: begin
          // Settle timer keeps running from the head change onward
          if (tmr_q != 8'h00) begin
            tmr_q <= tmr_q - 8'h01;
          end
          if (rdy_s2_q) begin
            if (cfg_q.head_only) begin
              st_q <= dfs_pkg::S_HWAIT;
            end else begin
              st_q <= dfs_pkg::S_RUN;
              go_tgl_q <= ~go_tgl_q;
            end
          end
        end
        dfs_pkg::S_HWAIT: begin
          if (tmr_q <= 8'h01) begin
            tmr_q <= 8'h00;
            st_q <= dfs_pkg::S_RUN;
            go_tgl_q <= ~go_tgl_q;
          end else begin
            tmr_q <= tmr_q - 8'h01;
          end
        end
        dfs_pkg::S_RUN: begin
          if (done_evt) begin
            st_q <= dfs_pkg::S_HOLD;
            tmr_q <= dfs_pkg::WE_OFF_CNT;
          end
        end
        dfs_pkg::S_HOLD: begin
          // No head change is accepted until write enable has been off long enough
          if (tmr_q <= 8'h01) begin
            tmr_q <= 8'h00;
            st_q <= dfs_pkg::S_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else begin
            tmr_q <= tmr_q - 8'h01;
          end
        end
        default: begin
          st_q <= dfs_pkg::S_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Job capture and drive selection; read enable stays low, so no splice is read over
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_q <= '0;
      unit_sel_q <= 1'b0;
      head_sel_q <= 2'h0;
      rd_en_q <= 1'b0;
    end else begin
      rd_en_q <= 1'b0;
      if (st_q == dfs_pkg::S_IDLE && start) begin
        cfg_q <= cfg;
        unit_sel_q <= 1'b1;
        head_sel_q <= cfg.head;
      end
    end
  end

  // ---------------- Link domain (servo clock) ----------------
  dfs_pkg::dfs_lnk_st_t lst_q;
  logic lrst_s1_q, lrst_n_q;
  logic go_s1_q, go_s2_q, go_s3_q;
  logic [2:0] pin_s1_q, pin_s2_q, pin_s3_q;
  logic start_evt, byte_tick, idx_edge, any_edge;
  logic [15:0] cnt_q;
  logic [7:0] sec_q;
  logic [1:0] lead_q;
  logic [7:0] sh_q;
  logic [15:0] crc_q;
  logic [7:0] tx_b;
  logic crc_start, crc_upd;
  logic [16:0] p, dend;
  logic more_sect;

  // Reset, start toggle and drive pins into the servo domain
  always_ff @(posedge srv_clk) begin
    lrst_s1_q <= reset_n;
    lrst_n_q <= lrst_s1_q;
    go_s1_q <= go_tgl_q;
    go_s2_q <= go_s1_q;
    go_s3_q <= go_s2_q;
    pin_s1_q <= {sector_pin, index_pin, byte_clk_pin};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end

  assign start_evt = go_s2_q ^ go_s3_q;
  // One byte clock per eight servo clocks paces the byte loads
  assign byte_tick = pin_s2_q[dfs_pkg::PIN_BYTE] & ~pin_s3_q[dfs_pkg::PIN_BYTE];
  assign idx_edge = pin_s2_q[dfs_pkg::PIN_INDEX] & ~pin_s3_q[dfs_pkg::PIN_INDEX];
  assign any_edge = idx_edge | (pin_s2_q[dfs_pkg::PIN_SECTOR] & ~pin_s3_q[dfs_pkg::PIN_SECTOR]);
  assign more_sect = ({1'b0, sec_q} + 9'h001) < {1'b0, cfg_q.n_sect};

  // Byte to record at the current offset within the sector
  always_comb begin
    p = {1'b0, cnt_q};
    dend = {1'b0, dfs_pkg::DAT_POS} + {1'b0, cfg_q.data_len};
    tx_b = 8'h00;
    crc_start = 1'b0;
    crc_upd = 1'b0;
    if (lst_q == dfs_pkg::L_FMT) begin
      if (cnt_q == dfs_pkg::ASB_POS) begin
        tx_b = cfg_q.sync_pat;
      end else if (cnt_q >= dfs_pkg::ADR_POS && cnt_q < dfs_pkg::ACRC_POS) begin
        crc_start = (cnt_q == dfs_pkg::ADR_POS);
        crc_upd = 1'b1;
        case (cnt_q - dfs_pkg::ADR_POS)
          16'h0000: tx_b = cfg_q.flag;
          16'h0001: tx_b = cfg_q.cyl[15:8];
          16'h0002: tx_b = cfg_q.cyl[7:0];
          16'h0003: tx_b = {6'h00, cfg_q.head};
          default: tx_b = sec_q;
        endcase
      end else if (cnt_q == dfs_pkg::ACRC_POS) begin
        tx_b = crc_q[15:8];
      end else if (cnt_q == dfs_pkg::ACRC_POS + 16'h0001) begin
        tx_b = crc_q[7:0];
      end else if (cnt_q == dfs_pkg::DSB_POS) begin
        tx_b = cfg_q.sync_pat;
      end else if (p >= {1'b0, dfs_pkg::DAT_POS} && p < dend) begin
        crc_start = (cnt_q == dfs_pkg::DAT_POS);
        crc_upd = 1'b1;
        tx_b = cfg_q.fill;
      end else if (p == dend) begin
        tx_b = crc_q[15:8];
      end else if (p == dend + 17'h00001) begin
        tx_b = crc_q[7:0];
      end
      // Pads, splice, data sync run and tail gap all fall to zero
    end
  end

  // Sector walk: index opens the track, each edge while more sectors remain restarts the count
  always_ff @(posedge srv_clk) begin
    if (!lrst_n_q) begin
      lst_q <= dfs_pkg::L_IDLE;
      lead_q <= 2'h0;
      cnt_q <= 16'h0000;
      sec_q <= 8'h00;
      done_tgl_q <= 1'b0;
      wr_q <= '0;
    end else begin
      case (lst_q)
        dfs_pkg::L_IDLE: begin
          if (start_evt) begin
            lst_q <= dfs_pkg::L_ARM;
            lead_q <= 2'h0;
            wr_q.wr_clk_gate <= 1'b1;
          end
        end
        dfs_pkg::L_ARM: begin
          // Index edges seen before the clock lead is complete are let pass
          if (lead_q != dfs_pkg::WCLK_LEAD_CNT) begin
            lead_q <= lead_q + 2'h1;
          end else if (idx_edge) begin
            lst_q <= dfs_pkg::L_FMT;
            wr_q.wr_en <= 1'b1;
            // A byte clock landing on the pulse already loads byte 0, a zero
            cnt_q <= {15'h0000, byte_tick};
            sec_q <= 8'h00;
          end
        end
        dfs_pkg::L_FMT: begin
          if (any_edge && more_sect) begin
            cnt_q <= {15'h0000, byte_tick};
            sec_q <= sec_q + 8'h01;
          end else if (any_edge && idx_edge) begin
            lst_q <= dfs_pkg::L_IDLE;
            wr_q.wr_en <= 1'b0;
            wr_q.wr_clk_gate <= 1'b0;
            done_tgl_q <= ~done_tgl_q;
          end else if (any_edge) begin
            lst_q <= dfs_pkg::L_LAST;
          end else if (byte_tick && cnt_q != 16'hffff) begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        dfs_pkg::L_LAST: begin
          // Zeros until index comes round again
          if (idx_edge) begin
            lst_q <= dfs_pkg::L_IDLE;
            wr_q.wr_en <= 1'b0;
            wr_q.wr_clk_gate <= 1'b0;
            done_tgl_q <= ~done_tgl_q;
          end
        end
        default: begin
          lst_q <= dfs_pkg::L_IDLE;
          wr_q.wr_en <= 1'b0;
        end
      endcase
      wr_q.wr_data <= sh_q[7];
    end
  end

  // Serialiser and check-code generator; a byte loads on each byte clock
  always_ff @(posedge srv_clk) begin
    if (!lrst_n_q) begin
      sh_q <= 8'h00;
      crc_q <= dfs_pkg::CRC_INIT;
    end else if (byte_tick) begin
      sh_q <= tx_b;
      if (crc_start) begin
        crc_q <= crc_byte(dfs_pkg::CRC_INIT, tx_b);
      end else if (crc_upd) begin
        crc_q <= crc_byte(crc_q, tx_b);
      end
    end else begin
      sh_q <= {sh_q[6:0], 1'b0};
    end
  end

  // ---------------- Checks ----------------
  property p_we_on_index;
    @(posedge srv_clk) disable iff (!lrst_n_q)
    $rose(wr_q.wr_en) |-> $past(idx_edge) && $past(lst_q) == dfs_pkg::L_ARM;
  endproperty
  a_we_on_index: assert property (p_we_on_index) else $error("write enable off index");

  property p_wclk_lead;
    @(posedge srv_clk) disable iff (!lrst_n_q)
    $rose(wr_q.wr_en) |-> $past(wr_q.wr_clk_gate, 3);
  endproperty
  a_wclk_lead: assert property (p_wclk_lead) else $error("write clock lead too short");

  property p_gap_zero;
    @(posedge srv_clk) disable iff (!lrst_n_q)
    (lst_q == dfs_pkg::L_FMT && byte_tick && cnt_q < dfs_pkg::ASB_POS) |=> sh_q == 8'h00;
  endproperty
  a_gap_zero: assert property (p_gap_zero) else $error("gap or sync byte not zero");

  property p_sync_pat;
    @(posedge srv_clk) disable iff (!lrst_n_q)
    (lst_q == dfs_pkg::L_FMT && byte_tick && cnt_q == dfs_pkg::ASB_POS)
      |=> sh_q == cfg_q.sync_pat ##1 sh_q == {cfg_q.sync_pat[6:0], 1'b0};
  endproperty
  a_sync_pat: assert property (p_sync_pat) else $error("sync pattern not sent");

  property p_splice_zero;
    @(posedge srv_clk) disable iff (!lrst_n_q)
    (lst_q == dfs_pkg::L_FMT && byte_tick && cnt_q >= dfs_pkg::ACRC_POS + 16'h0002
      && cnt_q < dfs_pkg::DSB_POS) |=> sh_q == 8'h00;
  endproperty
  a_splice_zero: assert property (p_splice_zero) else $error("pad or splice not zero");

  property p_acrc_hi;
    @(posedge srv_clk) disable iff (!lrst_n_q)
    (lst_q == dfs_pkg::L_FMT && byte_tick && cnt_q == dfs_pkg::ACRC_POS)
      |=> sh_q == $past(crc_q[15:8]);
  endproperty
  a_acrc_hi: assert property (p_acrc_hi) else $error("address check byte wrong");

  property p_last_zero;
    @(posedge srv_clk) disable iff (!lrst_n_q)
    (lst_q == dfs_pkg::L_LAST && byte_tick) |=> sh_q == 8'h00;
  endproperty
  a_last_zero: assert property (p_last_zero) else $error("tail not zero");

  property p_we_off;
    @(posedge srv_clk) disable iff (!lrst_n_q)
    $fell(wr_q.wr_en) |-> $past(idx_edge) ##1 lst_q == dfs_pkg::L_IDLE;
  endproperty
  a_we_off: assert property (p_we_off) else $error("write enable dropped off index");

  property p_restart;
    @(posedge srv_clk) disable iff (!lrst_n_q)
    (lst_q == dfs_pkg::L_FMT && any_edge && more_sect) |=> cnt_q == {15'h0000, $past(byte_tick)};
  endproperty
  a_restart: assert property (p_restart) else $error("byte count not restarted");

  property p_ready_first;
    @(posedge clk) disable iff (!reset_n)
    (st_q == dfs_pkg::S_RUN && $past(st_q) != dfs_pkg::S_RUN) |-> $past(rdy_s2_q, 1)
      || $past(st_q) == dfs_pkg::S_HWAIT;
  endproperty
  a_ready_first: assert property (p_ready_first) else $error("started without ready");

  property p_hold_time;
    @(posedge clk) disable iff (!reset_n)
    (st_q == dfs_pkg::S_RUN && done_evt) |=> busy_q [*8];
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("released before hold time");

  c_track_start: cover property (@(posedge srv_clk) $rose(wr_q.wr_en));
  c_next_sector: cover property (@(posedge srv_clk)
    lst_q == dfs_pkg::L_FMT && any_edge && more_sect);
  c_job_done: cover property (@(posedge clk) done_q);

endmodule

/* File: sim/dfs_drive_model.sv */
// Behavioural drive model: servo clock, byte clock, index and sector pulses, read data
`timescale 1ns/1ps
module dfs_drive_model #(
  parameter int SECT_BYTES = 64,
  parameter int N_SECT = 4
) (
  // Clock and position pulses towards the controller
  output logic srv_clk,
  output logic byte_clk_pin,
  output logic index_pin,
  output logic sector_pin,
  // Read path
  input wire logic rd_en,
  output logic rd_data
);
  localparam int REV = SECT_BYTES * N_SECT;
  int bit_n = 0;
  int byte_n = REV - 3;
  int lock_n = 0;

  // Servo clock runs free, the spindle is up to speed throughout
  initial begin
    srv_clk = 1'b0;
    #7;
    forever #24 srv_clk = ~srv_clk;
  end

  // Bit and byte position on the track, advanced just after each servo edge
  always @(posedge srv_clk) begin
    bit_n <= (bit_n + 1) % 8;
    if (bit_n == 7) begin
      byte_n <= (byte_n + 1) % REV;
    end
    lock_n <= rd_en ? lock_n + 1 : 0;
  end

  // One byte clock per eight servo clocks, pulses on byte boundaries
  assign byte_clk_pin = (bit_n < 4);
  assign index_pin = (byte_n == 0) && (bit_n < 4);
  assign sector_pin = (byte_n != 0) && (byte_n % SECT_BYTES == 0) && (bit_n < 4);
  // No media behind the model, so read data stays low until the oscillator has locked
  assign rd_data = (lock_n >= 88) ? bit_n[0] : 1'b0;
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the track formatter against a behavioural drive
`timescale 1ns/1ps
module testbench;
  localparam int SB = 64;
  localparam int NS = 4;
  localparam int REV = SB * NS;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic start = 1'b0;
  logic ready_pin = 1'b1;
  dfs_pkg::dfs_cfg_t cfg = '0;
  logic busy_q, done_q, unit_sel_q, rd_en_q, rd_data;
  logic [1:0] head_sel_q;
  logic srv_clk, byte_clk_pin, index_pin, sector_pin;
  dfs_pkg::dfs_wr_t wr_q;
  int err_count = 0;
  int n_compared = 0;
  int seed = 32'h3f28;
  int n_done = 0;
  logic bits[$];
  logic bad_cmd = 1'b0;
  logic bad_gate = 1'b0;
  realtime t_gate, t_we, t_wef, t_done;

  always #10 clk = ~clk;

  dfs_format_seq u_dfs_format_seq (.clk(clk), .reset_n(reset_n), .start(start), .cfg(cfg),
    .busy_q(busy_q), .done_q(done_q), .ready_pin(ready_pin), .unit_sel_q(unit_sel_q),
    .head_sel_q(head_sel_q), .rd_en_q(rd_en_q), .srv_clk(srv_clk),
    .byte_clk_pin(byte_clk_pin), .index_pin(index_pin), .sector_pin(sector_pin), .wr_q(wr_q));

  dfs_drive_model #(.SECT_BYTES(SB), .N_SECT(NS)) u_dfs_drive_model (.srv_clk(srv_clk),
    .byte_clk_pin(byte_clk_pin), .index_pin(index_pin), .sector_pin(sector_pin),
    .rd_en(rd_en_q), .rd_data(rd_data));

  // Record the written bit stream and the gate coverage in the link domain
  always @(posedge srv_clk) begin
    if (wr_q.wr_en === 1'b1) bits.push_back(wr_q.wr_data);
    if (wr_q.wr_en === 1'b1 && wr_q.wr_clk_gate !== 1'b1) bad_gate = 1'b1;
  end
  always @(posedge wr_q.wr_clk_gate) t_gate = $realtime;
  always @(posedge wr_q.wr_en) t_we = $realtime;
  always @(negedge wr_q.wr_en) t_wef = $realtime;

  // Job completion and command lines while a job runs
  always @(posedge clk) begin
    if (done_q === 1'b1) begin
      n_done++;
      t_done = $realtime;
    end
    if (busy_q === 1'b1 && (rd_en_q !== 1'b0 || rd_data !== 1'b0 || unit_sel_q !== 1'b1
        || head_sel_q !== cfg.head))
      bad_cmd = 1'b1;
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction

  // Expected byte at offset k of sector s, counted from that sector's pulse
  function automatic logic [7:0] exp_byte(int s, int k);
    logic [15:0] a;
    logic [15:0] d;
    int len;
    len = int'(cfg.data_len);
    a = crc_upd(crc_upd(crc_upd(16'hffff, cfg.flag), cfg.cyl[15:8]), cfg.cyl[7:0]);
    a = crc_upd(crc_upd(a, {6'h00, cfg.head}), 8'(s));
    d = 16'hffff;
    for (int i = 0; i < len; i++) d = crc_upd(d, cfg.fill);
    if (k == 23 || k == 44) return cfg.sync_pat;
    if (k == 24) return cfg.flag;
    if (k == 25) return cfg.cyl[15:8];
    if (k == 26) return cfg.cyl[7:0];
    if (k == 27) return {6'h00, cfg.head};
    if (k == 28) return 8'(s);
    if (k == 29) return a[15:8];
    if (k == 30) return a[7:0];
    if (k >= 45 && k < 45 + len) return cfg.fill;
    if (k == 45 + len) return d[15:8];
    if (k == 46 + len) return d[7:0];
    return 8'h00;
  endfunction

  // One format job from index to index, with a refused start while busy
  task automatic run_job(int n, bit ho, int rdly);
    dfs_pkg::dfs_cfg_t c;
    int p0;
    int nn;
    int a;
    int w;
    logic [7:0] sb;
    realtime t_start;
    realtime t_rdy;
    c = '0;
    c.sync_pat = 8'($random(seed)) | 8'h80;
    c.flag = 8'($random(seed));
    c.cyl = 16'($random(seed));
    c.head = 2'($random(seed));
    c.n_sect = 8'(n);
    c.data_len = 16'(1 + ($random(seed) & 7));
    c.fill = 8'($random(seed));
    c.head_only = ho;
    bits.delete();
    n_done = 0;
    bad_cmd = 1'b0;
    bad_gate = 1'b0;
    t_gate = 0;
    t_we = 0;
    t_done = 0;
    t_rdy = 0;
    @(posedge clk);
    if (rdly > 0) ready_pin <= 1'b0;
    @(posedge clk);
    cfg <= c;
    start <= 1'b1;
    t_start = $realtime;
    @(posedge clk);
    start <= 1'b0;
    if (rdly > 0) begin
      repeat (rdly) @(posedge clk);
      ready_pin <= 1'b1;
      t_rdy = $realtime;
    end
    // A second request while busy must leave the running job alone
    repeat (100) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    w = 0;
    while (n_done == 0 && w < 30000) begin
      @(posedge clk);
      w++;
    end
    repeat (20) @(posedge clk);
    check("done_pulses", 16'(n_done), 16'h0001);
    check("busy_after", {15'h0000, busy_q}, 16'h0000);
    check("cmd_lines", {15'h0000, bad_cmd}, 16'h0000);
    check("gate_cover", {15'h0000, bad_gate}, 16'h0000);
    check("gate_after_ready", 16'(t_gate > t_rdy), 16'h0001);
    if (ho) check("head_settle", 16'(t_we - t_start >= 5000.0), 16'h0001);
    check("gate_lead", 16'(t_we - t_gate >= 120.0), 16'h0001);
    check("release_to_done", 16'(t_done - t_wef >= 1000.0), 16'h0001);
    p0 = 0;
    while (p0 < bits.size() && bits[p0] === 1'b0) p0++;
    check("lead_zeros", 16'(p0 >= 176 && p0 <= 192), 16'h0001);
    check("track_bits", 16'(bits.size() >= REV * 8 - 16 && bits.size() <= REV * 8 + 16),
      16'h0001);
    nn = (n == 0) ? 1 : n;
    for (int j = 0; 23 + j < REV && p0 + 8 * j + 7 < bits.size(); j++) begin
      a = 23 + j;
      for (int b = 0; b < 8; b++) sb[7 - b] = bits[p0 + 8 * j + b];
      check("track_byte", {8'h00, sb},
        {8'h00, (a / SB < nn) ? exp_byte(a / SB, a % SB) : 8'h00});
    end
  endtask

  // Three cycles of reset; the servo side picks it up through its own synchroniser
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (20) @(posedge clk);
    run_job(4, 1'b0, 0);
    run_job(1, 1'b1, 0);
    run_job(0, 1'b0, 300);
    run_job(4, 1'($random(seed)), 0);
    final_report();
  end

  // Four jobs of about two revolutions each fit well inside this span
  initial begin
    #1500000;
    err_count++;
    final_report();
  end
endmodule
